// ### hw/sfc_map.svh
// Register map, field positions, reset values and timing constants
// Assumes the includer works on an 8-bit register port at 20 MHz
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SFC_ADDR_WAKE_THR 8'h1F
`define SFC_ADDR_FIFO_SEL 8'h23
`define SFC_ADDR_FRAME_SYNC_INPUT_STAT 8'h36
`define SFC_ADDR_PIN_CFG 8'h37
`define SFC_ADDR_IRQ_EN 8'h38
`define SFC_ADDR_IRQ_STAT 8'h3A
`define SFC_ADDR_MOTION_CTRL 8'h69

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFC_SEL_TEMP 7
`define SFC_SEL_RATE_X 6
`define SFC_SEL_RATE_Y 5
`define SFC_SEL_RATE_Z 4
`define SFC_SEL_ACCEL 3
`define SFC_FRAME_SYNC_INPUT_FLAG 7
`define SFC_CFG_ACT_LOW 7
`define SFC_CFG_OPEN_DRAIN 6
`define SFC_CFG_LATCH 5
`define SFC_CFG_ANY_RD_CLR 4
`define SFC_CFG_FS_LOW 3
`define SFC_CFG_FS_IRQ_ON 2
`define SFC_WAKE_HI 7
`define SFC_WAKE_LO 5
`define SFC_OVF_BIT 4
`define SFC_DRIVE_BIT 2
`define SFC_DRDY_BIT 0
`define SFC_MOT_ON 7
`define SFC_MOT_KIND 6

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define SFC_MASK_FIFO_SEL 8'hF8
`define SFC_MASK_PIN_CFG 8'hFC
`define SFC_MASK_IRQ_EN 8'hF5
`define SFC_MASK_MOTION 8'hC0
`define SFC_RST_REG 8'h00
`define SFC_WAKE_ALL 3'b111

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFC_CLK_KHZ 20000
`define SFC_PULSE_NS 50000
`define SFC_LAST_BYTE 4'hD

`endif

// ### hw/sfc_pkg.sv
// Types shared by the interrupt and FIFO source control block
// Assumes 16-bit sensor results handed in as one bundle per sample
package sfc_pkg;

  typedef struct packed {
    logic [15:0] accelX;
    logic [15:0] accelY;
    logic [15:0] accelZ;
    logic [15:0] tempVal;
    logic [15:0] rateX;
    logic [15:0] rateY;
    logic [15:0] rateZ;
  } sfc_sample_t;

  typedef enum logic [0:0] {
    SFC_IDLE = 1'b0,
    SFC_WALK = 1'b1
  } sfc_walk_t;

endpackage

// ### hw/sfc_motion_cmp.sv
// Consecutive-sample motion comparator for the accelerometer axes
// Assumes sampleTick is a one-cycle pulse with the sample valid beside it
`timescale 1ns/1ps
`include "sfc_map.svh"

module sfc_motion_cmp
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Sample stream
  input wire logic sampleTick,
  input wire sfc_sample_t sampleIn,
  // Control
  input wire logic detectOn,
  input wire logic compareKind,
  input wire logic [7:0] motion_wake_level,
  // Result
  output logic motionHit
);

  logic [15:0] prevX_q;
  logic [15:0] prevY_q;
  logic [15:0] prevZ_q;
  logic havePrev_q;

  function automatic logic overLevel(input logic [15:0] cur, input logic [15:0] prev,
                                     input logic [7:0] lvl);
    logic [16:0] diff;
    diff = {cur[15], cur} - {prev[15], prev};
    if (diff[16])
      diff = 17'h0_0000 - diff;
    overLevel = diff > {9'h000, lvl};
  endfunction

  // ----------------------------------------------------------------
  // Previous sample
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prevX_q <= 16'h0000;
      prevY_q <= 16'h0000;
      prevZ_q <= 16'h0000;
      havePrev_q <= 1'b0;
    end else if (sampleTick) begin
      prevX_q <= sampleIn.accelX;
      prevY_q <= sampleIn.accelY;
      prevZ_q <= sampleIn.accelZ;
      // First sample after switching on has nothing to compare with
      havePrev_q <= detectOn;
    end
  end

  // Only the compare-with-previous kind is usable; the other does nothing
  assign motionHit = sampleTick && detectOn && compareKind && havePrev_q &&
    (overLevel(sampleIn.accelX, prevX_q, motion_wake_level) ||
     overLevel(sampleIn.accelY, prevY_q, motion_wake_level) ||
     overLevel(sampleIn.accelZ, prevZ_q, motion_wake_level));

endmodule

// ### hw/sfc_ctrl.sv
// Interrupt pin and FIFO source control for a six-axis motion sensor
// Assumes a host register port and sensor events synchronous to sys_clk
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "sfc_map.svh"

module sfc_ctrl
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Sensor events and results
  input wire logic sampleTick,
  input wire sfc_sample_t sampleIn,
  input wire logic fifoOverflowEvt,
  input wire logic rateDriveReadyEvt,
  input wire logic frame_sync_input,
  // FIFO push stream
  output logic fifoPushValid,
  output logic [7:0] fifoPushData,
  // Interrupt pin, two-signal form
  output logic irq_output_pin,
  output logic irqPinOe
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int PULSE_CYC_RAW = (`SFC_PULSE_NS * (`SFC_CLK_KHZ / 1000)) / 1000;
  localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
  localparam logic [10:0] PULSE_LOAD = 11'(PULSE_CYC);

  // ----------------------------------------------------------------
  // Decoding shared by write and read paths
  // ----------------------------------------------------------------
  function automatic logic isAddr(input logic [7:0] addr, input logic [7:0] target);
    isAddr = (addr == target);
  endfunction

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] wakeThr_q;
  logic [7:0] fifoSel_q;
  logic [7:0] pinCfg_q;
  logic [7:0] irqEn_q;
  logic [7:0] motionCtrl_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wakeThr_q <= `SFC_RST_REG;
      fifoSel_q <= `SFC_RST_REG;
      pinCfg_q <= `SFC_RST_REG;
      irqEn_q <= `SFC_RST_REG;
      motionCtrl_q <= `SFC_RST_REG;
    end else if (regWr) begin
      if (isAddr(regAddr, `SFC_ADDR_WAKE_THR))
        wakeThr_q <= regWrData;
      if (isAddr(regAddr, `SFC_ADDR_FIFO_SEL))
        fifoSel_q <= regWrData & `SFC_MASK_FIFO_SEL;
      // Bit 0 is fixed at zero and bit 1 is reserved
      if (isAddr(regAddr, `SFC_ADDR_PIN_CFG))
        pinCfg_q <= regWrData & `SFC_MASK_PIN_CFG;
      if (isAddr(regAddr, `SFC_ADDR_IRQ_EN))
        irqEn_q <= regWrData & `SFC_MASK_IRQ_EN;
      if (isAddr(regAddr, `SFC_ADDR_MOTION_CTRL))
        motionCtrl_q <= regWrData & `SFC_MASK_MOTION;
    end
  end

  logic cfgActLow;
  logic cfgOpenDrain;
  logic cfgLatch;
  logic cfgAnyRdClr;
  logic cfgFsLow;
  logic cfgFsIrqOn;
  logic wakeIrqOn;
  logic motion_wake_irq_on;
  logic overflow_irq_on;
  logic rate_drive_ready_irq_on;
  logic dataReadyIrqOn;

  assign cfgActLow = pinCfg_q[`SFC_CFG_ACT_LOW];
  assign cfgOpenDrain = pinCfg_q[`SFC_CFG_OPEN_DRAIN];
  assign cfgLatch = pinCfg_q[`SFC_CFG_LATCH];
  assign cfgAnyRdClr = pinCfg_q[`SFC_CFG_ANY_RD_CLR];
  assign cfgFsLow = pinCfg_q[`SFC_CFG_FS_LOW];
  assign cfgFsIrqOn = pinCfg_q[`SFC_CFG_FS_IRQ_ON];
  // Partial patterns of the three-bit field count as disabled
  assign wakeIrqOn = irqEn_q[`SFC_WAKE_HI:`SFC_WAKE_LO] == `SFC_WAKE_ALL;
  assign motion_wake_irq_on = wakeIrqOn;
  assign overflow_irq_on = irqEn_q[`SFC_OVF_BIT];
  assign rate_drive_ready_irq_on = irqEn_q[`SFC_DRIVE_BIT];
  assign dataReadyIrqOn = irqEn_q[`SFC_DRDY_BIT];

  // ----------------------------------------------------------------
  // Motion-wake detection
  // ----------------------------------------------------------------
  logic motionHit;

  sfc_motion_cmp u_motion (
    .sys_clk(sys_clk),
    .srst(srst),
    .sampleTick(sampleTick),
    .sampleIn(sampleIn),
    .detectOn(motionCtrl_q[`SFC_MOT_ON]),
    .compareKind(motionCtrl_q[`SFC_MOT_KIND]),
    .motion_wake_level(wakeThr_q),
    .motionHit(motionHit)
  );

  // ----------------------------------------------------------------
  // Frame-sync edge detection
  // ----------------------------------------------------------------
  logic fsPrev_q;
  logic fsActive;
  logic fsEvent;

  // The raw pin is kept, so a polarity write alone never looks like an edge
  always_ff @(posedge sys_clk) begin
    fsPrev_q <= frame_sync_input;
  end

  assign fsActive = frame_sync_input ^ cfgFsLow;
  // Only the transition into the active level counts, not the level
  assign fsEvent = cfgFsIrqOn && fsActive && (frame_sync_input != fsPrev_q);

  // ----------------------------------------------------------------
  // Status flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  logic clrIrqStat;
  logic clrFsStat;
  logic motion_wake_flag;
  logic overflow_flag;
  logic rate_drive_ready_flag;
  logic dataReadyFlag_q;
  logic frameSyncFlag_q;
  logic wakeFlag_q;
  logic ovfFlag_q;
  logic driveFlag_q;

  assign clrIrqStat = regRd && (isAddr(regAddr, `SFC_ADDR_IRQ_STAT) || cfgAnyRdClr);
  assign clrFsStat = regRd && (isAddr(regAddr, `SFC_ADDR_FRAME_SYNC_INPUT_STAT) || cfgAnyRdClr);

  always_ff @(posedge sys_clk) begin
    if (srst)
      wakeFlag_q <= 1'b0;
    else if (motionHit)
      wakeFlag_q <= 1'b1;
    else if (clrIrqStat)
      wakeFlag_q <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst)
      ovfFlag_q <= 1'b0;
    else if (fifoOverflowEvt)
      ovfFlag_q <= 1'b1;
    else if (clrIrqStat)
      ovfFlag_q <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst)
      driveFlag_q <= 1'b0;
    else if (rateDriveReadyEvt)
      driveFlag_q <= 1'b1;
    else if (clrIrqStat)
      driveFlag_q <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst)
      dataReadyFlag_q <= 1'b0;
    else if (sampleTick)
      dataReadyFlag_q <= 1'b1;
    else if (clrIrqStat)
      dataReadyFlag_q <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst)
      frameSyncFlag_q <= 1'b0;
    else if (fsEvent)
      frameSyncFlag_q <= 1'b1;
    else if (clrFsStat)
      frameSyncFlag_q <= 1'b0;
  end

  assign motion_wake_flag = wakeFlag_q;
  assign overflow_flag = ovfFlag_q;
  assign rate_drive_ready_flag = driveFlag_q;

  // ----------------------------------------------------------------
  // Register read, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [7:0] irqStatus;
  logic [7:0] rdMux;

  always_comb begin
    irqStatus = 8'h00;
    irqStatus[`SFC_WAKE_HI:`SFC_WAKE_LO] = {3{motion_wake_flag}};
    irqStatus[`SFC_OVF_BIT] = overflow_flag;
    irqStatus[`SFC_DRIVE_BIT] = rate_drive_ready_flag;
    irqStatus[`SFC_DRDY_BIT] = dataReadyFlag_q;
  end

  always_comb begin
    rdMux = 8'h00;
    if (isAddr(regAddr, `SFC_ADDR_WAKE_THR))
      rdMux = wakeThr_q;
    else if (isAddr(regAddr, `SFC_ADDR_FIFO_SEL))
      rdMux = fifoSel_q;
    else if (isAddr(regAddr, `SFC_ADDR_FRAME_SYNC_INPUT_STAT))
      rdMux[`SFC_FRAME_SYNC_INPUT_FLAG] = frameSyncFlag_q;
    else if (isAddr(regAddr, `SFC_ADDR_PIN_CFG))
      rdMux = pinCfg_q;
    else if (isAddr(regAddr, `SFC_ADDR_IRQ_EN))
      rdMux = irqEn_q;
    else if (isAddr(regAddr, `SFC_ADDR_IRQ_STAT))
      rdMux = irqStatus;
    else if (isAddr(regAddr, `SFC_ADDR_MOTION_CTRL))
      rdMux = motionCtrl_q;
  end

  // Data stays valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (srst)
      regRdData <= 8'h00;
    else if (regRd)
      regRdData <= rdMux;
    else
      regRdData <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Interrupt request and pin
  // ----------------------------------------------------------------
  logic irqLevel;
  logic irqSetNow;
  logic [10:0] pulseCnt_q;
  logic irqAssert;
  logic pinLevel;

  assign irqLevel = (wakeFlag_q && motion_wake_irq_on) ||
                    (ovfFlag_q && overflow_irq_on) ||
                    (driveFlag_q && rate_drive_ready_irq_on) ||
                    (dataReadyFlag_q && dataReadyIrqOn) ||
                    frameSyncFlag_q;

  // A pulse starts on each new enabled event, even if its flag was already set
  assign irqSetNow = (motionHit && motion_wake_irq_on) ||
                     (fifoOverflowEvt && overflow_irq_on) ||
                     (rateDriveReadyEvt && rate_drive_ready_irq_on) ||
                     (sampleTick && dataReadyIrqOn) ||
                     fsEvent;

  always_ff @(posedge sys_clk) begin
    if (srst)
      pulseCnt_q <= 11'h000;
    else if (irqSetNow)
      pulseCnt_q <= PULSE_LOAD;
    else if (pulseCnt_q != 11'h000)
      pulseCnt_q <= pulseCnt_q - 11'h001;
  end

  assign irqAssert = cfgLatch ? irqLevel : (pulseCnt_q != 11'h000);
  assign pinLevel = irqAssert ^ cfgActLow;

  // Open drain only ever pulls low; the high level comes from the pull-up
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_output_pin <= 1'b0;
      irqPinOe <= 1'b1;
    end else if (cfgOpenDrain) begin
      irq_output_pin <= 1'b0;
      irqPinOe <= !pinLevel;
    end else begin
      irq_output_pin <= pinLevel;
      irqPinOe <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // FIFO source walker
  // ----------------------------------------------------------------
  sfc_walk_t walkState_q;
  sfc_sample_t snap_q;
  logic [7:0] selSnap_q;
  logic [3:0] byteIdx_q;

  // Byte order: accel X,Y,Z, temperature, rate X,Y,Z; high byte first
  function automatic logic byteSelected(input logic [3:0] idx, input logic [7:0] sel);
    logic [2:0] grp;
    grp = idx[3:1];
    case (grp)
      3'h0, 3'h1, 3'h2: byteSelected = sel[`SFC_SEL_ACCEL];
      3'h3: byteSelected = sel[`SFC_SEL_TEMP];
      3'h4: byteSelected = sel[`SFC_SEL_RATE_X];
      3'h5: byteSelected = sel[`SFC_SEL_RATE_Y];
      3'h6: byteSelected = sel[`SFC_SEL_RATE_Z];
      default: byteSelected = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] byteOf(input logic [3:0] idx, input sfc_sample_t s);
    logic [111:0] flat;
    flat = s;
    byteOf = flat[8'(111 - 8 * idx) -: 8];
  endfunction

  // A tick during a walk restarts it with the newest sample
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      walkState_q <= SFC_IDLE;
      byteIdx_q <= 4'h0;
      selSnap_q <= 8'h00;
      snap_q <= '0;
    end else if (sampleTick) begin
      walkState_q <= SFC_WALK;
      byteIdx_q <= 4'h0;
      selSnap_q <= fifoSel_q;
      snap_q <= sampleIn;
    end else begin
      unique case (walkState_q)
        SFC_IDLE: begin
          byteIdx_q <= 4'h0;
        end
        SFC_WALK: begin
          if (byteIdx_q == `SFC_LAST_BYTE)
            walkState_q <= SFC_IDLE;
          byteIdx_q <= byteIdx_q + 4'h1;
        end
      endcase
    end
  end

  // No standby input gates the selection, so idle paths still buffer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fifoPushValid <= 1'b0;
      fifoPushData <= 8'h00;
    end else if (walkState_q == SFC_WALK && !sampleTick) begin
      fifoPushValid <= byteSelected(byteIdx_q, selSnap_q);
      fifoPushData <= byteOf(byteIdx_q, snap_q);
    end else begin
      fifoPushValid <= 1'b0;
      fifoPushData <= 8'h00;
    end
  end

endmodule

// ### testbench/sfc_ctrl_properties.sv
// Port-level checks for the interrupt and FIFO source control block
// Assumes it is bound to sfc_ctrl and sees only that module's ports
`timescale 1ns/1ps

module sfc_ctrl_properties
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // Sensor side
  input wire logic sampleTick,
  input wire sfc_sample_t sampleIn,
  input wire logic fifoOverflowEvt,
  input wire logic rateDriveReadyEvt,
  input wire logic frame_sync_input,
  // Outputs
  input wire logic fifoPushValid,
  input wire logic [7:0] fifoPushData,
  input wire logic irq_output_pin,
  input wire logic irqPinOe
);
  // ----------------------------------------------------------------
  // Shadows of the pin-config, IRQ-enable and FIFO-select registers and a pin-high counter
  // ----------------------------------------------------------------
  logic [7:0] cfgQ, enQ, selQ;
  logic [10:0] hiQ;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfgQ <= 8'h00;
      enQ <= 8'h00;
      selQ <= 8'h00;
    end else if (regWr) begin
      if (regAddr == 8'h37) cfgQ <= regWrData & 8'hFC;
      if (regAddr == 8'h38) enQ <= regWrData & 8'hF5;
      if (regAddr == 8'h23) selQ <= regWrData & 8'hF8;
    end
  end
  // Saturates so a stuck pin cannot wrap back to a passing count
  always_ff @(posedge sys_clk) begin
    if (srst || !irq_output_pin) hiQ <= 11'h000;
    else if (hiQ != 11'h7FF) hiQ <= hiQ + 11'h001;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_READ_IDLE: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside the answer cycle");
  AST_TICK_GAP: assert property (sampleTick |=> !fifoPushValid)
    else $error("byte pushed in the cycle after a tick");
  AST_ACCEL_FIRST: assert property (sampleTick && selQ[3] |->
    ##2 fifoPushValid && fifoPushData == $past(sampleIn.accelX[15:8], 2))
    else $error("first accelerometer byte wrong");
  AST_TEMP_SLOT: assert property (sampleTick ##1 !sampleTick [*7] |->
    ##1 fifoPushValid == $past(selQ[7], 8))
    else $error("temperature slot valid wrong");
  AST_RATEZ_SLOT: assert property (sampleTick ##1 !sampleTick [*7] ##1 !sampleTick [*6] |->
    ##1 fifoPushValid == $past(selQ[4], 14))
    else $error("rate z slot valid wrong");
  AST_SRC_TO_PIN: assert property (cfgQ[6:5] == 2'b01 &&
    (fifoOverflowEvt && enQ[4] || rateDriveReadyEvt && enQ[2] || sampleTick && enQ[0])
    |-> ##2 irq_output_pin != cfgQ[7])
    else $error("enabled event did not assert the pin");
  AST_PULSE_WIDTH: assert property ($fell(irq_output_pin) && cfgQ[7:5] == 3'b000 |->
    hiQ == 11'h3E8)
    else $error("pulse width wrong");
  AST_ANY_READ_CLEAR: assert property (regRd && cfgQ[7:4] == 4'b0011 && !sampleTick &&
    !fifoOverflowEvt && !rateDriveReadyEvt && $stable(frame_sync_input) |-> ##2 !irq_output_pin)
    else $error("any read did not clear the pin");
  AST_FRAME_SYNC_INPUT_EDGE: assert property (cfgQ[7:4] == 4'b0010 && cfgQ[2] && (cfgQ[3] ?
    $fell(frame_sync_input) : $rose(frame_sync_input)) |-> ##2 irq_output_pin)
    else $error("frame sync edge did not assert the pin");
  AST_OPEN_DRAIN: assert property (cfgQ[6] == $past(cfgQ[6]) |->
    (cfgQ[6] ? !irq_output_pin : irqPinOe))
    else $error("pin drive type wrong");
  cover property (sampleTick && selQ[3]);
  cover property ($rose(irq_output_pin));
  cover property (regRd && regAddr == 8'h3A);
endmodule

// ### testbench/sfc_host_model.sv
// Host side of the register port: single-cycle write and read strobes
// Assumes one calling process, with tasks entered after a settled edge
`timescale 1ns/1ps

module sfc_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Released lines are inverted so a late sample cannot match by luck
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask
endmodule

// ### testbench/sfc_ctrl_test.sv
// Self-checking bench for the interrupt and FIFO source control block
// Assumes the host model drives the register port; pin line has a pull-up
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got %0h expected %0h", $time, g, e); end end

module sfc_ctrl_test
  import sfc_pkg::*;
;
  logic sys_clk, srst, sampleTick, fifoOverflowEvt, rateDriveReadyEvt, frame_sync_input;
  logic regWr, regRd, fifoPushValid, irq_output_pin, irqPinOe;
  logic [7:0] regAddr, regWrData, regRdData, fifoPushData, rdv, b;
  sfc_sample_t sampleIn, smp;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  logic [7:0] rowA [6] = '{8'h1F, 8'h23, 8'h37, 8'h38, 8'h69, 8'h50};
  logic [7:0] rowW [6] = '{8'hA5, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] rowE [6] = '{8'hA5, 8'hF8, 8'hFC, 8'hF5, 8'hC0, 8'h00};
  wire logic pinWire = irqPinOe ? irq_output_pin : 1'b1;

  sfc_ctrl DUT (.sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .sampleTick, .sampleIn, .fifoOverflowEvt, .rateDriveReadyEvt, .frame_sync_input,
    .fifoPushValid, .fifoPushData, .irq_output_pin, .irqPinOe);
  sfc_host_model host (.sys_clk, .regAddr, .regWrData, .regWr, .regRd, .regRdData);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic slotOn(logic [7:0] s, int i);
    if (i < 6) return s[3];
    return s[7 - (i - 6) / 2];
  endfunction
  task automatic cyc(int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    host.rd(a, rdv);
    `CHK(rdv, e)
  endtask
  task automatic clr();
    host.rd(8'h3A, rdv);
    host.rd(8'h36, rdv);
  endtask
  // Scrambling the sample after the tick exposes a late snapshot
  task automatic fire(int k, sfc_sample_t s);
    @(posedge sys_clk);
    sampleIn <= s;
    sampleTick <= (k == 0);
    fifoOverflowEvt <= (k == 1);
    rateDriveReadyEvt <= (k == 2);
    @(posedge sys_clk);
    sampleIn <= ~s;
    sampleTick <= 1'b0;
    fifoOverflowEvt <= 1'b0;
    rateDriveReadyEvt <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #(20000 * 50);
    num_errors++;
    print_verdict();
  end
  initial begin
    srst = 1'b1;
    sampleTick = 1'b0;
    fifoOverflowEvt = 1'b0;
    rateDriveReadyEvt = 1'b0;
    frame_sync_input = 1'b0;
    sampleIn = '0;
    smp = '{16'h1122, 16'h3344, 16'h5566, 16'h7788, 16'h99AA, 16'hBBCC, 16'hDDEE};
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      host.wr(rowA[i], rowW[i]);
      rdchk(rowA[i], rowE[i]);
    end
    $display("test register rows done");
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    cyc(1);
    `CHK(irqPinOe, 1'b1)
    `CHK(irq_output_pin, 1'b0)
    for (int i = 0; i < 5; i++) rdchk(rowA[i], 8'h00);
    $display("test mid-run reset done");
    for (int j = 0; j < 2; j++) begin
      b = (j == 0) ? 8'h88 : 8'h70;
      host.wr(8'h23, b);
      fire(0, smp);
      for (int i = 0; i < 14; i++) begin
        cyc(1);
        `CHK(fifoPushValid, slotOn(b, i))
        if (slotOn(b, i)) `CHK(fifoPushData, smp[111 - 8 * i -: 8])
      end
    end
    $display("test fifo sources done");
    host.wr(8'h37, 8'h20);
    clr();
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 8'h01 : (k == 1) ? 8'h10 : 8'h04;
      host.wr(8'h38, 8'h00);
      fire(k, smp);
      cyc(3);
      `CHK(pinWire, 1'b0)
      rdchk(8'h3A, b);
      host.wr(8'h38, b);
      fire(k, smp);
      cyc(20);
      `CHK(pinWire, 1'b1)
      rdchk(8'h3A, b);
      cyc(1);
      `CHK(pinWire, 1'b0)
    end
    $display("test latched sources done");
    host.wr(8'h38, 8'h01);
    host.wr(8'h37, 8'hA0);
    cyc(2);
    `CHK(pinWire, 1'b1)
    fire(0, smp);
    cyc(3);
    `CHK(pinWire, 1'b0)
    host.wr(8'h37, 8'hE0);
    cyc(2);
    `CHK(irqPinOe, 1'b1)
    `CHK(irq_output_pin, 1'b0)
    clr();
    cyc(2);
    `CHK(irqPinOe, 1'b0)
    // The earlier event left a pulse count running; let it expire first
    cyc(1000);
    host.wr(8'h37, 8'h00);
    fire(0, smp);
    cyc(1);
    n = 0;
    while (pinWire === 1'b1 && n < 2000) begin
      n++;
      cyc(1);
    end
    `CHK(n, 1000)
    clr();
    $display("test pin polarity drive pulse done");
    host.wr(8'h37, 8'h30);
    fire(0, smp);
    cyc(3);
    rdchk(8'h1F, 8'h00);
    cyc(1);
    `CHK(pinWire, 1'b0)
    rdchk(8'h3A, 8'h00);
    host.wr(8'h37, 8'h20);
    fire(0, smp);
    cyc(3);
    rdchk(8'h1F, 8'h00);
    cyc(1);
    `CHK(pinWire, 1'b1)
    rdchk(8'h3A, 8'h01);
    $display("test status clearing done");
    host.wr(8'h37, 8'h24);
    @(posedge sys_clk);
    frame_sync_input <= 1'b1;
    cyc(3);
    `CHK(pinWire, 1'b1)
    rdchk(8'h36, 8'h80);
    rdchk(8'h36, 8'h00);
    host.wr(8'h37, 8'h2C);
    @(posedge sys_clk);
    frame_sync_input <= 1'b0;
    cyc(3);
    rdchk(8'h36, 8'h80);
    host.wr(8'h37, 8'h20);
    @(posedge sys_clk);
    frame_sync_input <= 1'b1;
    cyc(3);
    rdchk(8'h36, 8'h00);
    $display("test frame sync done");
    host.wr(8'h69, 8'hC0);
    host.wr(8'h1F, 8'h10);
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h38, (k == 3) ? 8'h00 : 8'hE0);
      smp.accelX = (k == 0) ? 16'h0100 : (k == 1) ? 16'h0110 : (k == 2) ? 16'h00FF : 16'h0200;
      fire(0, smp);
      cyc(16);
      `CHK(pinWire, k == 2)
      rdchk(8'h3A, (k >= 2) ? 8'hE1 : 8'h01);
    end
    host.wr(8'h69, 8'h80);
    smp.accelX = 16'h0000;
    fire(0, smp);
    rdchk(8'h3A, 8'h01);
    $display("test motion wake done");
    print_verdict();
  end
endmodule

bind sfc_ctrl sfc_ctrl_properties chk (.sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .sampleTick, .sampleIn, .fifoOverflowEvt, .rateDriveReadyEvt, .frame_sync_input,
  .fifoPushValid, .fifoPushData, .irq_output_pin, .irqPinOe);
